// ==== verilog/core_exec_regs.svh ====
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH
// Register byte offsets on the Avalon slave
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_WREG 5'h08
`define OFS_PC 5'h0C
`define OFS_WDT 5'h10
// Control bit positions
`define CTRL_RUN 0
`define CTRL_PSA_T0 1
`define CTRL_WAKE 2
`define CTRL_WDT_EN 3
// Status bit positions
`define ST_SLEEP 0
`define ST_TIMEOUT 1
`define ST_POWERDOWN 2
`define ST_CARRY 3
`define ST_DIGIT_CARRY 4
`define ST_ZERO 5
// Reset values
`define CTRL_RESET 4'h0
`define PC_RESET 13'h0000
// Fixed instruction words
`define OP_RETURN 14'h0008
`define OP_SLEEP 14'h0063
`define OP_CLEAR_WATCHDOG_OP 14'h0064
// Opcode groups in bits 13:12
`define GRP_FILE 2'h0
`define GRP_BIT 2'h1
`define GRP_JUMP 2'h2
`define GRP_LIT 2'h3
// Sub-opcodes
`define BIT_SKIP_CLR 2'h2
`define BIT_SKIP_SET 2'h3
`define FILE_RLF 4'hD
`define LIT_IOR 4'h8
`define LIT_AND 4'h9
`define LIT_XOR 4'hA
// File addresses and call stack depth
`define TIMER0_COUNTER_ADDR 7'h01
`define PORT_FIRST 7'h05
`define PORT_LAST 7'h09
`define STACK_DEPTH 8
`endif

// ==== verilog/core_exec_pkg.sv ====
`default_nettype none
package core_exec_pkg;
    typedef enum logic [3:0] {
        OP_NOP, OP_SKIP_CLR, OP_SKIP_SET, OP_ADD, OP_AND, OP_IOR, OP_XOR,
        OP_SUB, OP_MOVE, OP_RETURN_WITH_LITERAL_OP, OP_CALL, OP_JUMP_OP, OP_RETURN, OP_SLEEP,
        OP_CLEAR_WATCHDOG_OP, OP_RLF
    } op_type;
    typedef enum logic [2:0] {
        ALU_MOVE, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_RLF
    } alu_op_type;
    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_FLUSH = 3'b010,
        ST_HALT = 3'b100
    } state_type;
endpackage : core_exec_pkg
`default_nettype wire

// ==== verilog/exec_links_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface stack_link #(parameter int AW = 13);
    logic push;
    logic pop;
    logic [AW-1:0] push_data;
    logic [AW-1:0] top;
    modport core (output push, output pop, output push_data, input top);
    modport mem (input push, input pop, input push_data, output top);
endinterface : stack_link

interface alu_link;
    core_exec_pkg::alu_op_type op;
    logic [7:0] operand;
    logic [7:0] w;
    logic c_in;
    logic [7:0] result;
    logic c;
    logic dc;
    logic z;
    modport core (output op, output operand, output w, output c_in,
                  input result, input c, input dc, input z);
    modport calc (input op, input operand, input w, input c_in,
                  output result, output c, output dc, output z);
endinterface : alu_link
`default_nettype wire

// ==== verilog/call_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
module call_stack #(
    parameter int DEPTH = 8,
    parameter int AW = 13
) (
    input wire logic clk_sys,
    input wire logic nrst,
    stack_link.mem lnk
);
    localparam int PW = $clog2(DEPTH);
    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;

    // Circular: overflow silently overwrites the oldest entry
    always_ff @(posedge clk_sys) begin
        if (lnk.push) begin
            mem[ptr] <= lnk.push_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ptr <= '0;
        end else if (lnk.push) begin
            ptr <= ptr + PW'(1);
        end else if (lnk.pop) begin
            ptr <= ptr - PW'(1);
        end
    end

    // Top kept in a register so the return target is ready without a read port delay
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lnk.top <= '0;
        end else if (lnk.push) begin
            lnk.top <= lnk.push_data;
        end else if (lnk.pop) begin
            lnk.top <= mem[ptr - PW'(2)];
        end
    end
endmodule : call_stack
`default_nettype wire

// ==== verilog/alu_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module alu_unit (
    alu_link.calc lnk
);
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        sum = 9'h000;
        low = 5'h00;
        lnk.c = lnk.c_in;
        lnk.dc = 1'b0;
        unique case (lnk.op)
            core_exec_pkg::ALU_ADD: begin
                sum = {1'b0, lnk.operand} + {1'b0, lnk.w};
                low = {1'b0, lnk.operand[3:0]} + {1'b0, lnk.w[3:0]};
                lnk.c = sum[8];
                lnk.dc = low[4];
            end
            core_exec_pkg::ALU_SUB: begin
                // Literal minus W by adding the two's complement; carry means no borrow
                sum = {1'b0, lnk.operand} + {1'b0, ~lnk.w} + 9'h001;
                low = {1'b0, lnk.operand[3:0]} + {1'b0, ~lnk.w[3:0]} + 5'h01;
                lnk.c = sum[8];
                lnk.dc = low[4];
            end
            core_exec_pkg::ALU_AND: sum = {1'b0, lnk.operand & lnk.w};
            core_exec_pkg::ALU_IOR: sum = {1'b0, lnk.operand | lnk.w};
            core_exec_pkg::ALU_XOR: sum = {1'b0, lnk.operand ^ lnk.w};
            core_exec_pkg::ALU_RLF: begin
                sum = {1'b0, lnk.operand[6:0], lnk.c_in};
                lnk.c = lnk.operand[7];
            end
            default: sum = {1'b0, lnk.operand};
        endcase
        lnk.result = sum[7:0];
        lnk.z = (sum[7:0] == 8'h00);
    end
endmodule : alu_unit
`default_nettype wire

// ==== verilog/mcu_instruction_exec_subset.sv ====
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "core_exec_regs.svh"
module mcu_instruction_exec_subset #(
    parameter int PC_W = 13,
    parameter int STACK_DEPTH = `STACK_DEPTH,
    parameter int WDT_PRE_W = 7
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [PC_W-1:0] pm_addr,
    input wire logic [13:0] pm_data,
    output logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] port_pin_level,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic timer0_counter_presc_clear,
    output logic osc_run,
    output logic wdt_timeout
);
    core_exec_pkg::state_type state;
    core_exec_pkg::op_type op;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [7:0] wreg;
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
    logic run;
    logic psa_t0;
    logic wdt_en;
    logic wake_req;
    logic rd_done;
    logic [WDT_PRE_W-1:0] wdt_presc;
    logic [7:0] watchdog_counter;
    logic wdt_overflow;
    logic exec_now;
    logic [7:0] operand;
    logic sel_bit;
    logic take_skip;
    logic changes_pc;
    logic dest_file;
    logic [31:0] next_readdata;

    stack_link #(.AW(PC_W)) stk ();
    alu_link alu ();

    call_stack #(.DEPTH(STACK_DEPTH), .AW(PC_W)) u_stack (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .lnk(stk)
    );

    alu_unit u_alu (
        .lnk(alu)
    );

    function automatic core_exec_pkg::op_type decode(input logic [13:0] iw);
        core_exec_pkg::op_type d;
        d = core_exec_pkg::OP_NOP;
        unique case (iw[13:12])
            `GRP_FILE: begin
                if (iw == `OP_RETURN) d = core_exec_pkg::OP_RETURN;
                else if (iw == `OP_SLEEP) d = core_exec_pkg::OP_SLEEP;
                else if (iw == `OP_CLEAR_WATCHDOG_OP) d = core_exec_pkg::OP_CLEAR_WATCHDOG_OP;
                else if (iw[11:8] == `FILE_RLF) d = core_exec_pkg::OP_RLF;
            end
            `GRP_BIT: begin
                if (iw[11:10] == `BIT_SKIP_CLR) d = core_exec_pkg::OP_SKIP_CLR;
                else if (iw[11:10] == `BIT_SKIP_SET) d = core_exec_pkg::OP_SKIP_SET;
            end
            `GRP_JUMP: begin
                d = iw[11] ? core_exec_pkg::OP_JUMP_OP : core_exec_pkg::OP_CALL;
            end
            `GRP_LIT: begin
                if (iw[11:10] == 2'h0) d = core_exec_pkg::OP_MOVE;
                else if (iw[11:10] == 2'h1) d = core_exec_pkg::OP_RETURN_WITH_LITERAL_OP;
                else if (iw[11:8] == `LIT_IOR) d = core_exec_pkg::OP_IOR;
                else if (iw[11:8] == `LIT_AND) d = core_exec_pkg::OP_AND;
                else if (iw[11:8] == `LIT_XOR) d = core_exec_pkg::OP_XOR;
                else if (iw[11:9] == 3'h6) d = core_exec_pkg::OP_SUB;
                else if (iw[11:9] == 3'h7) d = core_exec_pkg::OP_ADD;
            end
        endcase
        return d;
    endfunction : decode

    function automatic logic is_port(input logic [6:0] fa);
        return (fa >= `PORT_FIRST) && (fa <= `PORT_LAST);
    endfunction : is_port

    assign op = decode(pm_data);
    assign pm_addr = pc;
    assign file_raddr = pm_data[6:0];
    assign dest_file = pm_data[7];
    assign exec_now = (state == core_exec_pkg::ST_EXEC) && run;
    assign osc_run = (state != core_exec_pkg::ST_HALT);
    assign avs_waitrequest = avs_read && !rd_done;

    // Ports read back what the pins show, so a latch fighting an external driver is not kept
    assign operand = is_port(pm_data[6:0]) ? port_pin_level : file_rdata;
    assign sel_bit = operand[pm_data[9:7]];
    assign take_skip = ((op == core_exec_pkg::OP_SKIP_CLR) && !sel_bit)
        || ((op == core_exec_pkg::OP_SKIP_SET) && sel_bit);
    assign changes_pc = take_skip || (op == core_exec_pkg::OP_CALL)
        || (op == core_exec_pkg::OP_JUMP_OP) || (op == core_exec_pkg::OP_RETURN)
        || (op == core_exec_pkg::OP_RETURN_WITH_LITERAL_OP);

    always_comb begin
        alu.w = wreg;
        alu.c_in = carry;
        alu.operand = pm_data[7:0];
        unique case (op)
            core_exec_pkg::OP_ADD: alu.op = core_exec_pkg::ALU_ADD;
            core_exec_pkg::OP_SUB: alu.op = core_exec_pkg::ALU_SUB;
            core_exec_pkg::OP_AND: alu.op = core_exec_pkg::ALU_AND;
            core_exec_pkg::OP_IOR: alu.op = core_exec_pkg::ALU_IOR;
            core_exec_pkg::OP_XOR: alu.op = core_exec_pkg::ALU_XOR;
            core_exec_pkg::OP_RLF: begin
                alu.op = core_exec_pkg::ALU_RLF;
                alu.operand = operand;
            end
            default: alu.op = core_exec_pkg::ALU_MOVE;
        endcase
    end

    always_comb begin
        next_pc = pc + PC_W'(1);
        if (take_skip) begin
            next_pc = pc + PC_W'(2);
        end else if ((op == core_exec_pkg::OP_CALL) || (op == core_exec_pkg::OP_JUMP_OP)) begin
            next_pc = {pc[PC_W-1:11], pm_data[10:0]};
        end else if ((op == core_exec_pkg::OP_RETURN) || (op == core_exec_pkg::OP_RETURN_WITH_LITERAL_OP)) begin
            next_pc = stk.top;
        end
    end

    assign stk.push = exec_now && (op == core_exec_pkg::OP_CALL);
    assign stk.push_data = pc + PC_W'(1);
    assign stk.pop = exec_now && ((op == core_exec_pkg::OP_RETURN)
        || (op == core_exec_pkg::OP_RETURN_WITH_LITERAL_OP));

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= core_exec_pkg::ST_EXEC;
            pc <= `PC_RESET;
        end else begin
            unique case (state)
                core_exec_pkg::ST_EXEC: begin
                    if (run) begin
                        pc <= next_pc;
                        if (op == core_exec_pkg::OP_SLEEP) begin
                            state <= core_exec_pkg::ST_HALT;
                        end else if (changes_pc) begin
                            // The word fetched behind a taken branch is dropped
                            state <= core_exec_pkg::ST_FLUSH;
                        end
                    end
                end
                core_exec_pkg::ST_FLUSH: state <= core_exec_pkg::ST_EXEC;
                core_exec_pkg::ST_HALT: begin
                    if (wake_req || wdt_overflow) begin
                        state <= core_exec_pkg::ST_EXEC;
                    end
                end
                default: state <= core_exec_pkg::ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wreg <= 8'h00;
        end else if (exec_now) begin
            unique case (op)
                core_exec_pkg::OP_ADD, core_exec_pkg::OP_SUB, core_exec_pkg::OP_AND,
                core_exec_pkg::OP_IOR, core_exec_pkg::OP_XOR, core_exec_pkg::OP_MOVE,
                core_exec_pkg::OP_RETURN_WITH_LITERAL_OP: wreg <= alu.result;
                core_exec_pkg::OP_RLF: begin
                    if (!dest_file) wreg <= alu.result;
                end
                default: wreg <= wreg;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            carry <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero <= 1'b0;
        end else if (exec_now) begin
            unique case (op)
                core_exec_pkg::OP_ADD, core_exec_pkg::OP_SUB: begin
                    carry <= alu.c;
                    digit_carry_flag <= alu.dc;
                    zero <= alu.z;
                end
                core_exec_pkg::OP_AND, core_exec_pkg::OP_IOR,
                core_exec_pkg::OP_XOR: zero <= alu.z;
                core_exec_pkg::OP_RLF: carry <= alu.c;
                default: carry <= carry;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
            timer0_counter_presc_clear <= 1'b0;
        end else begin
            file_we <= exec_now && (op == core_exec_pkg::OP_RLF) && dest_file;
            file_waddr <= pm_data[6:0];
            file_wdata <= alu.result;
            timer0_counter_presc_clear <= exec_now && (op == core_exec_pkg::OP_RLF) && dest_file
                && (pm_data[6:0] == `TIMER0_COUNTER_ADDR) && psa_t0;
        end
    end

    // Watchdog runs on through the halt, as its own oscillator would
    assign wdt_overflow = wdt_en && (&wdt_presc) && (&watchdog_counter);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wdt_presc <= '0;
            watchdog_counter <= 8'h00;
            wdt_timeout <= 1'b0;
        end else begin
            wdt_timeout <= wdt_overflow;
            if (exec_now && ((op == core_exec_pkg::OP_SLEEP)
                || (op == core_exec_pkg::OP_CLEAR_WATCHDOG_OP))) begin
                wdt_presc <= '0;
                watchdog_counter <= 8'h00;
            end else if (wdt_en) begin
                wdt_presc <= wdt_presc + WDT_PRE_W'(1);
                if (&wdt_presc) begin
                    watchdog_counter <= watchdog_counter + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (exec_now && (op == core_exec_pkg::OP_SLEEP)) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
        end else if (exec_now && (op == core_exec_pkg::OP_CLEAR_WATCHDOG_OP)) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (wdt_overflow) begin
            timeout_flag <= 1'b0;
        end
    end

    localparam logic [3:0] CTRL_INIT = `CTRL_RESET;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            run <= CTRL_INIT[`CTRL_RUN];
            psa_t0 <= CTRL_INIT[`CTRL_PSA_T0];
            wdt_en <= CTRL_INIT[`CTRL_WDT_EN];
            wake_req <= CTRL_INIT[`CTRL_WAKE];
        end else begin
            wake_req <= 1'b0;
            if (avs_write && (avs_address == `OFS_CTRL)) begin
                run <= avs_writedata[`CTRL_RUN];
                psa_t0 <= avs_writedata[`CTRL_PSA_T0];
                wdt_en <= avs_writedata[`CTRL_WDT_EN];
                wake_req <= avs_writedata[`CTRL_WAKE];
            end
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            `OFS_CTRL: begin
                next_readdata[`CTRL_RUN] = run;
                next_readdata[`CTRL_PSA_T0] = psa_t0;
                next_readdata[`CTRL_WDT_EN] = wdt_en;
            end
            `OFS_STATUS: begin
                next_readdata[`ST_SLEEP] = (state == core_exec_pkg::ST_HALT);
                next_readdata[`ST_TIMEOUT] = timeout_flag;
                next_readdata[`ST_POWERDOWN] = powerdown_flag;
                next_readdata[`ST_CARRY] = carry;
                next_readdata[`ST_DIGIT_CARRY] = digit_carry_flag;
                next_readdata[`ST_ZERO] = zero;
            end
            `OFS_WREG: next_readdata[7:0] = wreg;
            `OFS_PC: next_readdata[PC_W-1:0] = pc;
            `OFS_WDT: next_readdata[7:0] = watchdog_counter;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // One wait state on reads lets read data come from a register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_done <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_done <= avs_read && !rd_done;
            if (avs_read && !rd_done) begin
                avs_readdata <= next_readdata;
            end
        end
    end
endmodule : mcu_instruction_exec_subset
`default_nettype wire

// ==== tb/exec_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "core_exec_regs.svh"
module exec_checker #(
    parameter int PC_W = 13
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic [13:0] pm_data,
    input wire logic [6:0] file_raddr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] port_pin_level,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    input wire logic timer0_counter_presc_clear,
    input wire logic osc_run,
    input wire logic wdt_timeout
);
    logic [7:0] operand;
    logic [7:0] prev_operand;
    logic [13:0] prev_word;
    logic prev_halt;
    // Ports are read at the pins, so the checker mirrors that choice
    assign operand = (file_raddr >= `PORT_FIRST && file_raddr <= `PORT_LAST) ?
        port_pin_level : file_rdata;
    always_ff @(posedge clk_sys) begin
        prev_operand <= operand;
        prev_word <= pm_data;
        prev_halt <= nrst & ~osc_run;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    sequence rd_answer;
        avs_read && !avs_waitrequest;
    endsequence
    a_read_one_wait: assert property (rd_wait |=> rd_answer)
        else $error("read not answered after one wait state");
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_unmapped_zero: assert property
        ((avs_read && !avs_waitrequest && avs_address > 5'h10) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_rotate_dest: assert property (file_we |-> prev_word[13:7] == 7'h1B &&
        file_waddr == prev_word[6:0]) else $error("file write without rotate to file");
    a_rotate_value: assert property (file_we |-> file_wdata[7:1] == prev_operand[6:0])
        else $error("rotate result wrong");
    a_presc_on_timer0_counter: assert property (timer0_counter_presc_clear |-> file_we &&
        file_waddr == `TIMER0_COUNTER_ADDR) else $error("prescaler cleared without timer write");
    a_sleep_halts: assert property ($fell(osc_run) |-> prev_word == `OP_SLEEP)
        else $error("halt without standby word");
    a_halt_holds_pc: assert property (!osc_run && prev_halt |-> $stable(pm_addr))
        else $error("pc moved while halted");
    a_wdt_pulse: assert property (wdt_timeout |=> !wdt_timeout)
        else $error("watchdog pulse too long");
endmodule : exec_checker
bind mcu_instruction_exec_subset exec_checker #(.PC_W(PC_W)) u_exec_checker (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pm_addr(pm_addr), .pm_data(pm_data), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .port_pin_level(port_pin_level), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .file_we(file_we), .timer0_counter_presc_clear(timer0_counter_presc_clear), .osc_run(osc_run),
    .wdt_timeout(wdt_timeout));
`default_nettype wire

// ==== tb/prog_file_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module prog_file_model (
    input wire logic clk_sys,
    input wire logic [12:0] pm_addr,
    output logic [13:0] pm_data,
    input wire logic [6:0] file_raddr,
    output logic [7:0] file_rdata,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we
);
    logic [13:0] prog [0:255];
    logic [7:0] regs [0:127];
    initial begin
        for (int i = 0; i < 256; i++) begin
            prog[i] = 14'h0000;
        end
        for (int i = 0; i < 128; i++) begin
            regs[i] = 8'h00;
        end
    end
    // Only 256 words are modelled; fetches beyond read as no-operation
    assign pm_data = (pm_addr < 13'h0100) ? prog[pm_addr[7:0]] : 14'h0000;
    assign file_rdata = regs[file_raddr];
    always @(posedge clk_sys) begin
        if (file_we) begin
            regs[file_waddr] <= file_wdata;
        end
    end
endmodule : prog_file_model
`default_nettype wire

// ==== tb/mcu_instruction_exec_subset_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_exec_subset_test;
    logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, file_we;
    logic timer0_counter_presc_clear, osc_run, wdt_timeout;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [12:0] pm_addr;
    logic [13:0] pm_data;
    logic [6:0] file_raddr, file_waddr;
    logic [7:0] file_rdata, file_wdata, port_pin_level;
    logic [13:0] code [0:15];
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int presc_seen = 0;
    int n;
    mcu_instruction_exec_subset #(.WDT_PRE_W(2)) u_mcu_instruction_exec_subset (
        .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .pm_data(pm_data),
        .file_raddr(file_raddr), .file_rdata(file_rdata), .port_pin_level(port_pin_level),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .file_we(file_we),
        .timer0_counter_presc_clear(timer0_counter_presc_clear), .osc_run(osc_run), .wdt_timeout(wdt_timeout));
    prog_file_model u_prog_file_model (
        .clk_sys(clk_sys), .pm_addr(pm_addr), .pm_data(pm_data), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .file_we(file_we));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (timer0_counter_presc_clear === 1'b1) begin
            presc_seen++;
        end
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_write
    task automatic rd_cmp(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        cmp(rd, exp);
    endtask : rd_cmp
    task automatic test_reset_values();
        rd_cmp(5'h04, 32'h0000_0006);
        rd_cmp(5'h08, 32'h0000_0000);
        rd_cmp(5'h0C, 32'h0000_0000);
        bus_write(5'h14, 32'hFFFF_FFFF);
        rd_cmp(5'h14, 32'h0000_0000);
        $display("test_reset_values done");
    endtask : test_reset_values
    task automatic test_program_run();
        // Run with the prescaler assigned to timer0
        bus_write(5'h00, 32'h0000_0003);
        n = 0;
        while (osc_run !== 1'b0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        // 19 instruction cycles; the first falling edge counted comes before any of them
        cmp(n, 20);
        cmp(osc_run, 1'b0);
        rd_cmp(5'h08, 32'h0000_0005);
        rd_cmp(5'h04, 32'h0000_0013);
        rd_cmp(5'h0C, 32'h0000_000C);
        cmp(u_prog_file_model.regs[32], 8'h03);
        cmp(u_prog_file_model.regs[5], 8'h02);
        cmp(u_prog_file_model.regs[1], 8'h01);
        cmp(presc_seen, 1);
        $display("test_program_run done");
    endtask : test_program_run
    task automatic test_wake_literal();
        bus_write(5'h00, 32'h0000_0007);
        n = 0;
        while (pm_addr !== 13'h000F && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        rd_cmp(5'h08, 32'h0000_0002);
        rd_cmp(5'h04, 32'h0000_0006);
        rd_cmp(5'h0C, 32'h0000_000F);
        $display("test_wake_literal done");
    endtask : test_wake_literal
    task automatic test_watchdog();
        bus_write(5'h00, 32'h0000_000B);
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        cmp(n > 1000 && n < 1040, 1'b1);
        rd_cmp(5'h04, 32'h0000_0004);
        $display("test_watchdog done");
    endtask : test_watchdog
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        port_pin_level = 8'h81;
        code = '{14'h2020, 14'h3801, 14'h3A43, 14'h3C05, 14'h18A0, 14'h30EE, 14'h1C20,
            14'h30DD, 14'h0DA0, 14'h0D85, 14'h0D81, 14'h0063, 14'h3E01, 14'h3902,
            14'h0064, 14'h280F};
        #1;
        for (int i = 0; i < 16; i++) begin
            u_prog_file_model.prog[i] = code[i];
        end
        u_prog_file_model.prog[32] = 14'h2022;
        u_prog_file_model.prog[33] = 14'h3442;
        u_prog_file_model.prog[34] = 14'h0008;
        u_prog_file_model.regs[32] = 8'h01;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        test_reset_values();
        test_program_run();
        test_wake_literal();
        test_watchdog();
        end_of_test();
    end
endmodule : mcu_instruction_exec_subset_test
`default_nettype wire
